// [hdl/hbridge_pkg.sv]
/*
  package for the single h-bridge control logic: timing counts, mode
  enumeration, register map of the ahb-lite slave and carrier structs.
  assumes a 10 MHz system clock.
*/
package hbridge_pkg;

	// timing
	localparam int unsigned CLK_PERIOD_NS   = 100;
	localparam int unsigned WAKE_TIME_MS    = 10;
	localparam int unsigned WAKE_CYCLES     = (WAKE_TIME_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned DEAD_TIME_NS    = 200;
	localparam int unsigned DEAD_CYCLES     =
		(DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned THERM_BAND_NS   = 1000;
	localparam int unsigned THERM_CYCLES    =
		(THERM_BAND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned OVC_BAND_NS     = 1000;
	localparam int unsigned OVC_CYCLES      =
		(OVC_BAND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WAKE_W          = 17;
	localparam int unsigned CNT_W           = 8;

	// register map, byte addresses
	localparam logic [11:0] CTRL_OFS        = 12'h000;
	localparam logic [11:0] STAT_OFS        = 12'h004;

	// control field positions
	localparam int unsigned CTRL_ENABLE_BIT = 0;
	localparam int unsigned CTRL_DIR_BIT    = 1;
	localparam int unsigned CTRL_RECIRC_BIT = 2;
	localparam logic [2:0]  CTRL_RESET      = 3'h0;

	// status field positions
	localparam int unsigned STAT_THERM_BIT  = 0;
	localparam int unsigned STAT_OVC_BIT    = 1;
	localparam int unsigned STAT_AWAKE_BIT  = 2;
	localparam int unsigned STAT_MODE_LSB   = 3;

	// bridge modes, gray in listed order off-charge-fast-slow-dead
	typedef enum logic [2:0] {
		MODE_OFF    = 3'b000,
		MODE_CHARGE = 3'b001,
		MODE_FAST   = 3'b011,
		MODE_SLOW   = 3'b010,
		MODE_DEAD   = 3'b110
	} bridge_mode_e;

	// gate drive of the four switches
	typedef struct packed {
		logic highSideA;
		logic highSideB;
		logic lowSideA;
		logic lowSideB;
	} gate_s;

	localparam gate_s GATES_OFF = 4'h0;

	// raw comparator inputs
	typedef struct packed {
		logic overTemp;
		logic overCurrent;
		logic limitReached;
	} sense_s;

endpackage

// [hdl/hbridge_fault_sleep_control.sv]
/*
  control logic of a single h-bridge brushed-motor driver: sleep and fault
  clear pins, open-drain fault flag, bridge mode decode with dead time,
  auto-returning thermal trip, latching overcurrent trip, ahb-lite slave.
  assumes pins synchronous to clk except the analog comparator results.
*/
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module hbridge_fault_sleep_control
	import hbridge_pkg::*;
#(
	parameter int unsigned WAKE_COUNT = WAKE_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        standbySelect_n,
	input  wire logic        faultClear_n,
	input  wire sense_s      sense,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output gate_s            gates,
	output logic             regulatorEnable,
	output logic             oscEnable,
	output logic             faultFlagOut,
	output logic             faultFlagOe_n
);

	// combined clear terms
	logic sleepClr;
	logic logicClr;
	assign sleepClr = rst | ~standbySelect_n;
	assign logicClr = sleepClr | ~faultClear_n;

	// comparator synchronisers
	sense_s syncA_q, syncA_d, syncB_q, syncB_d;
	// ahb state
	logic        wrPend_q, wrPend_d, rdPend_q, rdPend_d;
	logic [11:0] addr_q, addr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic [2:0]  ctrl_q, ctrl_d;
	// fault state
	logic [CNT_W-1:0] thermCnt_q, thermCnt_d, ovcCnt_q, ovcCnt_d;
	logic             thermTrip_q, thermTrip_d, ovcTrip_q, ovcTrip_d;
	// wake and bridge state
	logic [WAKE_W-1:0] wakeCnt_q, wakeCnt_d;
	logic              awake_q, awake_d;
	bridge_mode_e      mode_q, mode_d, target_q, target_d;
	logic              dir_q, dir_d;
	logic [CNT_W-1:0]  deadCnt_q, deadCnt_d;
	gate_s             gates_d;
	logic              flag_d, reg_d, osc_d;
	bridge_mode_e      want;
	logic              anyTrip;
	logic [31:0]       status;

	// two-stage synchroniser, first stage read only by second
	always_comb begin
		syncA_d = sense;
		syncB_d = syncA_q;
	end

	// ahb-lite slave, zero wait states, writes land in data phase
	always_comb begin
		wrPend_d = 1'b0;
		rdPend_d = 1'b0;
		addr_d   = addr_q;
		ctrl_d   = ctrl_q;
		hrdata_d = hrdata_q;
		if (wrPend_q && addr_q == CTRL_OFS)
			ctrl_d = hwdata[2:0];
		if (hsel && hready && htrans[1]) begin
			wrPend_d = hwrite;
			rdPend_d = ~hwrite;
			addr_d   = haddr[11:0];
			case (haddr[11:0])
				CTRL_OFS: hrdata_d = {29'h0, ctrl_d};
				STAT_OFS: hrdata_d = status;
				default:  hrdata_d = 32'h0;
			endcase
		end
		if (sleepClr)
			ctrl_d = CTRL_RESET;
	end

	// status word read by software
	assign status = {26'h0, mode_q, awake_q, ovcTrip_q, thermTrip_q};

	// trip detection with dead bands
	always_comb begin
		thermCnt_d  = thermCnt_q;
		thermTrip_d = thermTrip_q;
		ovcCnt_d    = ovcCnt_q;
		ovcTrip_d   = ovcTrip_q;
		if (!syncB_q.overTemp) begin
			thermCnt_d  = '0;
			thermTrip_d = 1'b0;
		end else if (thermCnt_q >= CNT_W'(THERM_CYCLES - 1)) begin
			thermTrip_d = 1'b1;
		end else begin
			thermCnt_d = thermCnt_q + CNT_W'(1);
		end
		if (!syncB_q.overCurrent)
			ovcCnt_d = '0;
		else if (ovcCnt_q >= CNT_W'(OVC_CYCLES - 1))
			ovcTrip_d = 1'b1;
		else
			ovcCnt_d = ovcCnt_q + CNT_W'(1);
		if (logicClr) begin
			ovcTrip_d = 1'b0;
			ovcCnt_d  = '0;
		end
		// sleep clears both trips; fault clear does not
		if (sleepClr) begin
			thermTrip_d = 1'b0;
			thermCnt_d  = '0;
		end
	end

	assign anyTrip = thermTrip_q | ovcTrip_q;

	// requested mode from control and current limit
	always_comb begin
		want = MODE_OFF;
		if (ctrl_q[CTRL_ENABLE_BIT]) begin
			// limit reached leaves charge; decay select
			if (syncB_q.limitReached)
				want = ctrl_q[CTRL_RECIRC_BIT] ? MODE_FAST : MODE_SLOW;
			else
				want = MODE_CHARGE;
		end
	end

	// wake timer, bridge mode sequencer with dead time
	always_comb begin
		wakeCnt_d = wakeCnt_q;
		awake_d   = awake_q;
		mode_d    = mode_q;
		target_d  = target_q;
		dir_d     = dir_q;
		deadCnt_d = deadCnt_q;
		if (!awake_q) begin
			if (wakeCnt_q >= WAKE_W'(WAKE_COUNT - 1))
				awake_d = 1'b1;
			else
				wakeCnt_d = wakeCnt_q + WAKE_W'(1);
		end
		case (mode_q)
			MODE_DEAD: begin
				if (deadCnt_q >= CNT_W'(DEAD_CYCLES - 1))
					mode_d = target_q;
				else
					deadCnt_d = deadCnt_q + CNT_W'(1);
			end
			MODE_OFF, MODE_CHARGE, MODE_FAST, MODE_SLOW: begin
				// every change, a direction flip too, passes dead time
				if ((want != mode_q || ctrl_q[CTRL_DIR_BIT] != dir_q)
					&& awake_q && !anyTrip) begin
					mode_d    = MODE_DEAD;
					target_d  = want;
					// direction only reaches the gates after the gap
					dir_d     = ctrl_q[CTRL_DIR_BIT];
					deadCnt_d = '0;
				end
			end
			default: mode_d = MODE_OFF;
		endcase
		if (anyTrip || !awake_q)
			mode_d = MODE_OFF;
		if (sleepClr) begin
			wakeCnt_d = '0;
			awake_d   = 1'b0;
			deadCnt_d = '0;
			target_d  = MODE_OFF;
			dir_d     = 1'b0;
		end
		if (logicClr)
			mode_d = MODE_OFF;
	end

	// gate decode and pin outputs
	always_comb begin
		gates_d = GATES_OFF;
		case (mode_d)
			MODE_CHARGE: begin
				gates_d.highSideA = ~dir_q;
				gates_d.lowSideB  = ~dir_q;
				gates_d.highSideB = dir_q;
				gates_d.lowSideA  = dir_q;
			end
			MODE_FAST: begin
				gates_d.highSideB = ~dir_q;
				gates_d.lowSideA  = ~dir_q;
				gates_d.highSideA = dir_q;
				gates_d.lowSideB  = dir_q;
			end
			MODE_SLOW: begin
				gates_d.lowSideA = 1'b1;
				gates_d.lowSideB = 1'b1;
			end
			default: gates_d = GATES_OFF;
		endcase
		// trip switches off all, flag low
		if (thermTrip_d || ovcTrip_d)
			gates_d = GATES_OFF;
		// open drain: oe low drives low; release on clear
		// flag follows trip, so a quick clear gives a short pulse
		flag_d = ~(thermTrip_d | ovcTrip_d);
		reg_d = ~sleepClr;
		osc_d = ~sleepClr;
	end

	// registers
	always_ff @(posedge clk) begin
		syncA_q <= syncA_d;
		syncB_q <= syncB_d;
		if (rst) begin
			wrPend_q        <= 1'b0;
			rdPend_q        <= 1'b0;
			addr_q          <= 12'h000;
			hrdata_q        <= 32'h0000_0000;
			ctrl_q          <= CTRL_RESET;
			thermCnt_q      <= '0;
			ovcCnt_q        <= '0;
			thermTrip_q     <= 1'b0;
			ovcTrip_q       <= 1'b0;
			wakeCnt_q       <= '0;
			awake_q         <= 1'b0;
			mode_q          <= MODE_OFF;
			target_q        <= MODE_OFF;
			dir_q           <= 1'b0;
			deadCnt_q       <= '0;
			gates           <= GATES_OFF;
			faultFlagOe_n   <= 1'b1;
			regulatorEnable <= 1'b0;
			oscEnable       <= 1'b0;
		end else begin
			wrPend_q        <= wrPend_d;
			rdPend_q        <= rdPend_d;
			addr_q          <= addr_d;
			hrdata_q        <= hrdata_d;
			ctrl_q          <= ctrl_d;
			thermCnt_q      <= thermCnt_d;
			ovcCnt_q        <= ovcCnt_d;
			thermTrip_q     <= thermTrip_d;
			ovcTrip_q       <= ovcTrip_d;
			wakeCnt_q       <= wakeCnt_d;
			awake_q         <= awake_d;
			mode_q          <= mode_d;
			target_q        <= target_d;
			dir_q           <= dir_d;
			deadCnt_q       <= deadCnt_d;
			gates           <= gates_d;
			faultFlagOe_n   <= flag_d;
			regulatorEnable <= reg_d;
			oscEnable       <= osc_d;
		end
	end

	// constant bus answers and flag data
	always_ff @(posedge clk) begin
		hreadyout    <= 1'b1;
		hresp        <= 1'b0;
		faultFlagOut <= 1'b0;
	end

	assign hrdata = hrdata_q;

	// assertions
	// trip gives dead gates and low flag
	property p_trip_off;
		@(posedge clk) disable iff (rst)
		(thermTrip_q || ovcTrip_q) |-> (gates == GATES_OFF && !faultFlagOe_n);
	endproperty
	a_trip_off: assert property (p_trip_off) else $error("trip left gates on");

	property p_ovc_latch;
		@(posedge clk) disable iff (rst)
		(ovcTrip_q && standbySelect_n && faultClear_n) |=> ovcTrip_q;
	endproperty
	a_ovc_latch: assert property (p_ovc_latch) else $error("overcurrent not latched");

	property p_ovc_clear;
		@(posedge clk) disable iff (rst)
		!faultClear_n |=> !ovcTrip_q;
	endproperty
	a_ovc_clear: assert property (p_ovc_clear) else $error("fault clear ignored");

	property p_sleep_clear;
		@(posedge clk) disable iff (rst)
		!standbySelect_n |=> (!thermTrip_q && !ovcTrip_q && !awake_q && !regulatorEnable);
	endproperty
	a_sleep_clear: assert property (p_sleep_clear) else $error("sleep did not clear");

	property p_therm_keep;
		@(posedge clk) disable iff (rst)
		(thermTrip_q && standbySelect_n && syncB_q.overTemp) |=> thermTrip_q;
	endproperty
	a_therm_keep: assert property (p_therm_keep) else $error("thermal lost");

	property p_therm_return;
		@(posedge clk) disable iff (rst)
		(thermTrip_q && !syncB_q.overTemp) |=> !thermTrip_q;
	endproperty
	a_therm_return: assert property (p_therm_return) else $error("thermal latched");

	property p_no_shoot;
		@(posedge clk) disable iff (rst)
		!(gates.highSideA && gates.lowSideA) && !(gates.highSideB && gates.lowSideB);
	endproperty
	a_no_shoot: assert property (p_no_shoot) else $error("shoot-through");

	property p_dead_gap;
		@(posedge clk) disable iff (rst)
		(mode_q != MODE_DEAD && $past(mode_q) != MODE_DEAD && $changed(mode_q))
			|-> (mode_q == MODE_OFF || mode_q == MODE_DEAD);
	endproperty
	a_dead_gap: assert property (p_dead_gap) else $error("mode change without dead time");

	property p_ovc_band;
		@(posedge clk) disable iff (rst)
		$rose(ovcTrip_q) |-> $past(syncB_q.overCurrent, 2);
	endproperty
	a_ovc_band: assert property (p_ovc_band) else $error("overcurrent without band");

	c_ovc: cover property (@(posedge clk) disable iff (rst) $rose(ovcTrip_q));
	c_therm: cover property (@(posedge clk) disable iff (rst) $fell(thermTrip_q));
	c_fast: cover property (@(posedge clk) disable iff (rst) mode_q == MODE_FAST);
	c_wake: cover property (@(posedge clk) disable iff (rst) $rose(awake_q));

endmodule

`default_nettype wire

// [tb/load_model.sv]
/*
  far-side model: motor current ramp with limit comparator and the pull-up
  on the open-drain fault pin.
  assumes the gate struct of hbridge_pkg and a direction hint from the bench.
*/
`timescale 1ns/10ps
`default_nettype none

module load_model
	import hbridge_pkg::*;
(
	input  wire logic       clk,
	input  wire gate_s      gates,
	input  wire logic       dirNeg,
	input  wire logic [7:0] limitLevel,
	input  wire logic       faultFlagOut,
	input  wire logic       faultFlagOe_n,
	output logic            limitReached,
	output wire logic       faultPin
);
	logic [7:0] current_q = 8'h00;
	logic       charging;

	// charge drives current in the selected direction only
	assign charging = dirNeg ? (gates.highSideB & gates.lowSideA)
		: (gates.highSideA & gates.lowSideB);

	// current rises in charge, decays otherwise
	always_ff @(posedge clk) begin
		if (charging)
			current_q <= current_q + 8'h01;
		else if (current_q != 8'h00)
			current_q <= current_q - 8'h01;
	end

	assign limitReached = (current_q >= limitLevel);
	assign faultPin = faultFlagOe_n ? 1'b1 : faultFlagOut;
endmodule

`default_nettype wire

// [tb/testbench.sv]
/*
  self-checking bench for the h-bridge control: ahb-lite tasks, pin stimulus,
  mode, trip, clear and sleep sequences.
  assumes one slave on the bus and a shortened wake count.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import hbridge_pkg::*;
	localparam int WAKE = 20;
	logic        clk, rst, standbySelect_n, faultClear_n, overTemp, overCurrent;
	logic        hsel, hwrite, hreadyout, hresp, dirNeg, limitReached, faultPin;
	logic        regulatorEnable, oscEnable, faultFlagOut, faultFlagOe_n;
	logic [31:0] haddr, hwdata, hrdata, rdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	gate_s       gates, gatesPrev;
	int          failures, total_checks;

	hbridge_fault_sleep_control #(.WAKE_COUNT(WAKE)) dut (.clk(clk), .rst(rst),
		.standbySelect_n(standbySelect_n), .faultClear_n(faultClear_n),
		.sense({overTemp, overCurrent, limitReached}), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.gates(gates), .regulatorEnable(regulatorEnable), .oscEnable(oscEnable),
		.faultFlagOut(faultFlagOut), .faultFlagOe_n(faultFlagOe_n));

	load_model load (.clk(clk), .gates(gates), .dirNeg(dirNeg), .limitLevel(8'h1E),
		.faultFlagOut(faultFlagOut), .faultFlagOe_n(faultFlagOe_n),
		.limitReached(limitReached), .faultPin(faultPin));

	// clock generator
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// single word transfer, address then data phase
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		htrans <= 2'h2;
		haddr  <= {20'h00000, a};
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdata = hrdata;
	endtask

	task automatic waitGates(input gate_s exp);
		int n;
		n = 0;
		while (gates !== exp && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(32'(gates), 32'(exp));
	endtask

	task automatic pins(input logic s, input logic c, input logic t, input logic o, input int n);
		@(posedge clk);
		standbySelect_n <= s;
		faultClear_n    <= c;
		overTemp        <= t;
		overCurrent     <= o;
		repeat (n) @(posedge clk);
		#1;
	endtask

	// no shoot-through, and every change passes through all-off
	always @(posedge clk) begin
		gatesPrev <= gates;
		if (!rst && ((gates.highSideA & gates.lowSideA) | (gates.highSideB & gates.lowSideB)
			| (gatesPrev != GATES_OFF && gates != GATES_OFF && gates != gatesPrev))) begin
			failures++;
			$display("mismatch at %0t: gates %h after %h", $time, gates, gatesPrev);
		end
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("mismatch at %0t: timeout %h %h", $time, 1'b0, 1'b1);
		summarize();
	end

	initial begin
		failures = 0;
		total_checks = 0;
		{rst, standbySelect_n, faultClear_n, hsel} = 4'hF;
		{overTemp, overCurrent, hwrite, dirNeg} = 4'h0;
		{haddr, hwdata, htrans, hsize} = {32'h0, 32'h0, 2'h0, 3'h2};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check({gates, faultPin, hreadyout, hresp}, 7'h06);
		bus(1'b1, 12'h010, 32'hFFFFFFFF);
		bus(1'b0, 12'h010, 32'h0);
		check(rdata, 32'h0);
		bus(1'b0, CTRL_OFS, 32'h0);
		check(rdata, 32'h0);
		repeat (WAKE) @(posedge clk);
		bus(1'b0, STAT_OFS, 32'h0);
		check({rdata[STAT_AWAKE_BIT], regulatorEnable, oscEnable}, 3'h7);
		// all direction and recirculation combinations
		for (int i = 0; i < 4; i++) begin
			dirNeg <= i[0];
			bus(1'b1, CTRL_OFS, {29'h0, i[1], i[0], 1'b1});
			waitGates(i[0] ? 4'h6 : 4'h9);
			waitGates(i[1] ? (i[0] ? 4'h9 : 4'h6) : 4'h3);
			bus(1'b1, CTRL_OFS, 32'h0);
			waitGates(GATES_OFF);
		end
		// direction flip while running must pass through all-off
		dirNeg <= 1'b0;
		bus(1'b1, CTRL_OFS, 32'h1);
		waitGates(4'h9);
		dirNeg <= 1'b1;
		bus(1'b1, CTRL_OFS, 32'h3);
		waitGates(4'h6);
		// thermal trip, clear pin ignored, auto return
		dirNeg <= 1'b0;
		bus(1'b1, CTRL_OFS, 32'h1);
		waitGates(4'h9);
		// 2 sync stages plus 10 band cycles, with margin
		pins(1'b1, 1'b1, 1'b1, 1'b0, 15);
		check(gates, GATES_OFF);
		check(faultPin, 1'b0);
		pins(1'b1, 1'b0, 1'b1, 1'b0, 3);
		pins(1'b1, 1'b1, 1'b1, 1'b0, 3);
		check(faultPin, 1'b0);
		bus(1'b1, CTRL_OFS, 32'h1);
		pins(1'b1, 1'b1, 1'b0, 1'b0, 0);
		waitGates(4'h9);
		check(faultPin, 1'b1);
		// short spike filtered, long one latches
		pins(1'b1, 1'b1, 1'b0, 1'b1, 5);
		pins(1'b1, 1'b1, 1'b0, 1'b0, 20);
		check(faultPin, 1'b1);
		pins(1'b1, 1'b1, 1'b0, 1'b1, 15);
		check(gates, GATES_OFF);
		pins(1'b1, 1'b1, 1'b0, 1'b0, 30);
		check({gates, faultPin}, 5'h00);
		pins(1'b1, 1'b0, 1'b0, 1'b0, 2);
		pins(1'b1, 1'b1, 1'b0, 1'b0, 2);
		check(faultPin, 1'b1);
		// clear pin held low keeps bridge off
		bus(1'b1, CTRL_OFS, 32'h1);
		waitGates(4'h9);
		pins(1'b1, 1'b0, 1'b0, 1'b0, 6);
		check(gates, GATES_OFF);
		// latched trip cleared by sleep
		pins(1'b1, 1'b1, 1'b0, 1'b0, 2);
		bus(1'b1, CTRL_OFS, 32'h1);
		pins(1'b1, 1'b1, 1'b0, 1'b1, 15);
		check(faultPin, 1'b0);
		pins(1'b0, 1'b1, 1'b0, 1'b0, 4);
		check({regulatorEnable, oscEnable, gates, faultPin}, 7'h01);
		pins(1'b1, 1'b1, 1'b0, 1'b0, 2);
		bus(1'b0, CTRL_OFS, 32'h0);
		check(rdata, 32'h0);
		bus(1'b0, STAT_OFS, 32'h0);
		check({rdata[STAT_AWAKE_BIT], gates}, 5'h00);
		repeat (WAKE) @(posedge clk);
		bus(1'b0, STAT_OFS, 32'h0);
		check(rdata[STAT_AWAKE_BIT], 1'b1);
		summarize();
	end
endmodule

`default_nettype wire
